// file: src/scc_pkg.sv
// Types shared by the serial channel switch control modules.
// Assumes scc_regs.svh is on the include path.
package scc_pkg;
  typedef logic [4:0] scc_chan_t;
  typedef logic [7:0] scc_byte_t;
  typedef enum logic [1:0] {SCC_IDLE, SCC_START, SCC_DATA, SCC_STOP}
    scc_ser_t;
endpackage : scc_pkg

// file: src/scc_regs.svh
// Constants for the serial channel switch control block.
// Assumes a 100 MHz reference clock; included by bare name.
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH
`define SCC_CLK_HZ       100000000
`define SCC_BAUD         19200
`define SCC_BIT_CYCLES   (`SCC_CLK_HZ / `SCC_BAUD)
`define SCC_DATA_BITS    8
`define SCC_STOP_BITS    1
`define SCC_CODE_BASE    8'h10
`define SCC_CODE_LAST    8'h1F
`define SCC_CODE_OFF     8'h71
`define SCC_CHAN_OFF     5'h00
`define SCC_CHAN_LAST    5'h10
`define SCC_CASCADE_DIGITS 4
`endif

// file: src/scc_top.sv
// Serial channel switch control: 8N1 receiver, command decode, echo.
// Assumes RXD is synchronous to REF_CLK and idles high.
// Assumes SYNC_MODE and the local request come from configuration logic.
// Summary of operation
// - Link runs 19200 baud, 8N1
// - No handshake; echo each valid command byte; only taken and echoed in sync mode
// - Codes 10h to 1Fh select ports 1 to 16
// - Code 71h selects channel zero, video off
// - Channel change transmits matching control byte; only sent in sync mode
// - Received byte switches slave to master's channel
// - Remote switching only in sync mode, equal baud
// - Cascade addresses: two digits per level, four max; not parsed in this block
`timescale 1ns/1ps
`include "scc_regs.svh"
module scc_top
#(
  parameter int BIT_CYCLES = `SCC_BIT_CYCLES
)
(
  input  wire logic         REF_CLK,
  input  wire logic         RST,
  input  wire logic         RXD,
  input  wire logic         SYNC_MODE,
  input  wire logic         LOCAL_SEL,
  input  wire scc_pkg::scc_chan_t LOCAL_CHAN,
  output logic              TXD,
  output scc_pkg::scc_chan_t CHANNEL,
  output logic              VIDEO_ON,
  output logic              CHAN_CHANGED
);
  import scc_pkg::*;

  function automatic logic code_valid(input scc_byte_t b);
    code_valid = (b >= `SCC_CODE_BASE && b <= `SCC_CODE_LAST)
                 || b == `SCC_CODE_OFF;
  endfunction : code_valid

  function automatic scc_byte_t chan_code(input scc_chan_t c);
    chan_code = (c == `SCC_CHAN_OFF) ? `SCC_CODE_OFF
                : `SCC_CODE_BASE + 8'(c - 5'h01);
  endfunction : chan_code

  // Code to channel; only called on codes that passed code_valid
  function automatic scc_chan_t code_chan(input scc_byte_t b);
    code_chan = (b == `SCC_CODE_OFF) ? `SCC_CHAN_OFF
                : 5'(b - `SCC_CODE_BASE) + 5'h01;
  endfunction : code_chan

  scc_tx_if   txq();
  logic [12:0] rdiv;
  scc_ser_t    rstate;
  scc_byte_t   rshift;
  logic [2:0]  ridx;
  logic        rx_done;
  scc_byte_t   rx_byte;
  logic        echo_pend;
  scc_byte_t   echo_byte;
  logic        note_pend;
  scc_byte_t   note_byte;
  scc_chan_t   next_channel;
  logic        take_rx;
  logic        take_loc;
  logic        half_pt;
  logic        full_pt;

  assign half_pt = (rdiv == 13'((BIT_CYCLES / 2) - 1));
  assign full_pt = (rdiv == 13'(BIT_CYCLES - 1));

  // Receiver: sample mid-bit at 19200 baud, 8 data, 1 stop
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      rdiv <= 13'h0000;
    // Restarting at mid start puts every later sample mid-bit
    else if (rstate == SCC_IDLE || full_pt
             || (rstate == SCC_START && half_pt))
      rdiv <= 13'h0000;
    else
      rdiv <= rdiv + 13'h0001;
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      rstate  <= SCC_IDLE;
      rshift  <= 8'h00;
      ridx    <= 3'h0;
    end
    else
    begin
      unique case (rstate)
        SCC_IDLE:
          if (!RXD)
            rstate <= SCC_START;
        SCC_START:
          if (half_pt)
          begin
            // A short glitch is not a start bit
            rstate <= RXD ? SCC_IDLE : SCC_DATA;
            ridx   <= 3'h0;
          end
        SCC_DATA:
          if (full_pt)
          begin
            rshift <= {RXD, rshift[7:1]};
            ridx   <= ridx + 3'h1;
            if (ridx == 3'h7)
              rstate <= SCC_STOP;
          end
        SCC_STOP:
          if (full_pt)
            rstate <= SCC_IDLE;
      endcase
    end
  end

  // Frame result; a low stop bit is a framing error and drops the byte
  // rx_done is a one-cycle strobe, so each frame acts only once
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      rx_done <= 1'b0;
      rx_byte <= 8'h00;
    end
    else
    begin
      rx_done <= (rstate == SCC_STOP) && full_pt && RXD;
      if (rstate == SCC_STOP && full_pt)
        rx_byte <= rshift;
    end
  end

  // Remote commands count only in sync mode and only when valid
  assign take_rx  = rx_done && SYNC_MODE && code_valid(rx_byte);
  // Local requests above the last port are ignored; remote ones win
  assign take_loc = LOCAL_SEL && !take_rx
                    && LOCAL_CHAN <= `SCC_CHAN_LAST;

  // Next channel: a remote command, else a local request, else hold
  always_comb
  begin
    next_channel = CHANNEL;
    if (take_rx)
      next_channel = code_chan(rx_byte);
    else if (take_loc)
      next_channel = LOCAL_CHAN;
  end

  // Channel state; a remote command wins over a local request
  // VIDEO_ON follows the next value so it never lags CHANNEL
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      CHANNEL      <= `SCC_CHAN_OFF;
      VIDEO_ON     <= 1'b0;
      CHAN_CHANGED <= 1'b0;
    end
    else
    begin
      CHANNEL      <= next_channel;
      VIDEO_ON     <= (next_channel != `SCC_CHAN_OFF);
      CHAN_CHANGED <= (next_channel != CHANNEL);
    end
  end

  // Echo; only one echo outstanding, a newer one overwrites
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      echo_pend <= 1'b0;
      echo_byte <= 8'h00;
    end
    else if (take_rx)
    begin
      echo_pend <= 1'b1;
      echo_byte <= rx_byte;
    end
    else if (txq.ready && echo_pend)
      echo_pend <= 1'b0;
  end

  // Change notice only for local switching: a remote change is already
  // echoed, so sending twice would double-switch chained slaves
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      note_pend <= 1'b0;
      note_byte <= 8'h00;
    end
    else if (take_loc && next_channel != CHANNEL && SYNC_MODE)
    begin
      note_pend <= 1'b1;
      note_byte <= chan_code(next_channel);
    end
    else if (txq.ready && !echo_pend && note_pend)
      note_pend <= 1'b0;
  end

  assign txq.valid = echo_pend || note_pend;
  assign txq.data  = echo_pend ? echo_byte : note_byte;

  // One serialiser carries both; an echo always goes first
  scc_uart_tx
  #(
    .BIT_CYCLES (BIT_CYCLES)
  )
  u_tx
  (
    .clk (REF_CLK),
    .rst (RST),
    .tx  (txq.snk),
    .txd (TXD)
  );

  // Cascade addressing two digits per level and four at most
  // is resolved above this block: no digit pairs are parsed here
  // and nothing is forwarded to a unit below.
endmodule : scc_top

// file: src/scc_tx_if.sv
// Transmit request carrier between the interpreter and serialiser.
// Assumes a single clock domain.
`timescale 1ns/1ps
interface scc_tx_if;
  import scc_pkg::*;
  logic      valid;
  logic      ready;
  scc_byte_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : scc_tx_if

// file: src/scc_uart_tx.sv
// 8N1 serialiser driven by one-cycle bit enables from a divider.
// Assumes the requester holds valid and data until ready.
`timescale 1ns/1ps
`include "scc_regs.svh"
module scc_uart_tx
#(
  parameter int BIT_CYCLES = `SCC_BIT_CYCLES
)
(
  input  wire logic clk,
  input  wire logic rst,
  scc_tx_if.snk     tx,
  output logic      txd
);
  import scc_pkg::*;
  logic [12:0] div;
  logic        bit_en;
  scc_ser_t    state;
  scc_byte_t   shreg;
  logic [2:0]  idx;

  assign bit_en   = (div == 13'(BIT_CYCLES - 1));
  assign tx.ready = (state == SCC_IDLE);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      div <= 13'h0000;
    else if (state == SCC_IDLE || bit_en)
      div <= 13'h0000;
    else
      div <= div + 13'h0001;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= SCC_IDLE;
      shreg <= 8'h00;
      idx   <= 3'h0;
      txd   <= 1'b1;
    end
    else
    begin
      unique case (state)
        SCC_IDLE:
          if (tx.valid)
          begin
            shreg <= tx.data;
            txd   <= 1'b0;
            state <= SCC_START;
          end
        SCC_START:
          if (bit_en)
          begin
            txd   <= shreg[0];
            idx   <= 3'h0;
            state <= SCC_DATA;
          end
        SCC_DATA:
          if (bit_en)
          begin
            if (idx == 3'h7)
            begin
              txd   <= 1'b1;
              state <= SCC_STOP;
            end
            else
            begin
              txd   <= shreg[idx + 3'h1];
              idx   <= idx + 3'h1;
            end
          end
        SCC_STOP:
          if (bit_en)
            state <= SCC_IDLE;
      endcase
    end
  end
endmodule : scc_uart_tx

// file: verif/scc_remote.sv
// Remote controller model: sends command frames, collects echoes.
// Assumes 8N1 at BIT_CYCLES clocks a bit; the line idles high.
`timescale 1ns/1ps
module scc_remote
#(
  parameter int BIT_CYCLES = 16
)
(
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);
  logic [7:0] got [$];
  logic [7:0] sh;
  initial rxd = 1'b1;
  // Stop low only where a refusal is wanted
  task automatic send(input logic [7:0] b, input logic stp = 1'b1);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk) rxd <= f[i];
      repeat (BIT_CYCLES - 1) @(posedge clk);
    end
    @(posedge clk) rxd <= 1'b1;
    // A low stop looks like a new start; idle long enough to refute it
    if (!stp)
      repeat (BIT_CYCLES) @(posedge clk);
  endtask : send
  // Mid-bit sampling, LSB first, no handshake
  always
  begin
    @(negedge txd);
    repeat (BIT_CYCLES / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYCLES) @(posedge clk);
      sh[i] = txd;
    end
    repeat (BIT_CYCLES) @(posedge clk);
    if (txd)
      got.push_back(sh);
  end
endmodule : scc_remote

// file: verif/scc_top_asserts.sv
// Port checker for scc_top, bound below.
// Frame timing follows the BIT_CYCLES of the bound instance.
`timescale 1ns/1ps
module scc_top_asserts
#(
  parameter int BIT_CYCLES = 16
)
(
  input wire logic               REF_CLK,
  input wire logic               RST,
  input wire logic               RXD,
  input wire logic               SYNC_MODE,
  input wire logic               LOCAL_SEL,
  input wire scc_pkg::scc_chan_t LOCAL_CHAN,
  input wire logic               TXD,
  input wire scc_pkg::scc_chan_t CHANNEL,
  input wire logic               VIDEO_ON,
  input wire logic               CHAN_CHANGED
);
  import scc_pkg::*;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  localparam int FRAME_CYCLES = 10 * BIT_CYCLES;
  logic        txd_q;
  logic        tx_busy;
  logic [15:0] tx_age;
  logic        frame_start;
  // Data bits fall too; only a fall on an idle line opens a frame
  assign frame_start = !tx_busy && txd_q && !TXD;
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      txd_q   <= 1'b1;
      tx_busy <= 1'b0;
      tx_age  <= 16'h0000;
    end
    else
    begin
      txd_q <= TXD;
      if (frame_start)
      begin
        tx_busy <= 1'b1;
        tx_age  <= 16'h0001;
      end
      else if (tx_busy && tx_age == 16'(FRAME_CYCLES - 1))
      begin
        tx_busy <= 1'b0;
        tx_age  <= 16'h0000;
      end
      else if (tx_busy)
        tx_age <= tx_age + 16'h0001;
    end
  end
  video_tie_a: assert property (VIDEO_ON == (CHANNEL != 5'h00))
    else $error("video flag wrong");
  chan_range_a: assert property (CHANNEL <= 5'h10)
    else $error("channel too high");
  start_bit_a: assert property (frame_start |-> !TXD [*8])
    else $error("start bit short");
  stop_bit_a:
    assert property (tx_busy && tx_age == 16'((19 * BIT_CYCLES) / 2)
      |-> TXD)
    else $error("stop bit missing");
  chg_flag_a:
    assert property ($changed(CHANNEL) |-> ##[0:1] CHAN_CHANGED)
    else $error("no change pulse");
  flag_once_a: assert property (CHAN_CHANGED |=> !CHAN_CHANGED)
    else $error("long change pulse");
  local_take_a:
    assert property (LOCAL_SEL && LOCAL_CHAN <= 5'h10 |=>
      CHANNEL == $past(LOCAL_CHAN))
    else $error("local pick lost");
  local_drop_a:
    assert property (LOCAL_SEL && LOCAL_CHAN > 5'h10 |=> $stable(CHANNEL))
    else $error("bad pick taken");
  cover property ($fell(TXD));
  cover property ($changed(CHANNEL) ##1 CHANNEL == 5'h00);
  cover property (LOCAL_SEL && LOCAL_CHAN > 5'h10);
endmodule : scc_top_asserts
bind scc_top scc_top_asserts #(.BIT_CYCLES(BIT_CYCLES)) chk_i
  (.REF_CLK(REF_CLK), .RST(RST), .RXD(RXD), .SYNC_MODE(SYNC_MODE),
   .LOCAL_SEL(LOCAL_SEL), .LOCAL_CHAN(LOCAL_CHAN), .TXD(TXD),
   .CHANNEL(CHANNEL), .VIDEO_ON(VIDEO_ON), .CHAN_CHANGED(CHAN_CHANGED));

// file: verif/tb_top.sv
// Bench for scc_top: remote model, refusals, local picks.
// Assumes a 16-clock bit time so frames stay short.
`timescale 1ns/1ps
module tb_top;
  import scc_pkg::*;
  localparam int BC = 16;
  logic      clk = 1'b0;
  logic      rst = 1'b1;
  logic      sync = 1'b1;
  logic      lsel = 1'b0;
  scc_chan_t lch = 5'h00;
  logic      rxd, txd;
  scc_chan_t ch;
  logic      von;
  int        bad_count = 0;
  int        cmp_count = 0;
  always #5 clk = ~clk;
  scc_top #(.BIT_CYCLES(BC)) uut (.REF_CLK(clk), .RST(rst), .RXD(rxd),
    .SYNC_MODE(sync), .LOCAL_SEL(lsel), .LOCAL_CHAN(lch), .TXD(txd),
    .CHANNEL(ch), .VIDEO_ON(von), .CHAN_CHANGED());
  scc_remote #(.BIT_CYCLES(BC)) peer (.clk(clk), .txd(txd), .rxd(rxd));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("FAIL %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic report_and_stop;
    if (bad_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // Waits out a whole echo frame before reading back
  task automatic echo(input logic [7:0] e [$]);
    repeat (12 * BC) @(posedge clk);
    chk(8'(peer.got.size()), 8'(e.size()));
    foreach (e[i])
      chk(peer.got[i], e[i]);
    peer.got.delete();
  endtask : echo
  task automatic pick(input scc_chan_t c);
    lsel <= 1'b1;
    lch <= c;
    @(posedge clk);
    lsel <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pick
  // Frames back to back, so echoes overlap the next command
  task automatic t_codes;
    logic [7:0] q [$];
    logic [7:0] c;
    for (int i = 0; i < 17; i++)
    begin
      c = (i < 16) ? 8'h10 + 8'(i) : 8'h71;
      q.push_back(c);
      peer.send(c);
      chk({3'h0, ch}, (i < 16) ? 8'(i + 1) : 8'h00);
      chk({7'h00, von}, (i < 16) ? 8'h01 : 8'h00);
    end
    echo(q);
  endtask : t_codes
  task automatic t_refuse;
    peer.send(8'h1A);
    peer.send(8'h20);
    peer.send(8'h0F);
    peer.send(8'h70);
    peer.send(8'h13, 1'b0);
    sync <= 1'b0;
    peer.send(8'h15);
    chk({3'h0, ch}, 8'h0B);
    pick(5'h03);
    echo({8'h1A});
    sync <= 1'b1;
  endtask : t_refuse
  task automatic t_local;
    pick(5'h05);
    echo({8'h14});
    pick(5'h00);
    echo({8'h71});
    pick(5'h11);
    chk({3'h0, ch}, 8'h00);
  endtask : t_local
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({3'h0, ch}, 8'h00);
    t_codes();
    t_refuse();
    t_local();
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
endmodule : tb_top
